// ### design/srl_pkg.sv
/*
 * srl_pkg: constants and carrier types for the status read link service
 * responder.
 * assumes: payload words arrive big-endian, first word is the command word.
 */
package srl_pkg;

    // ****************************************************************
    // command and reply words
    // ****************************************************************
    localparam logic [31:0] CMD_XCHG_STAT = 32'h0800_0000;
    localparam logic [31:0] CMD_SEQ_STAT = 32'h0900_0000;
    localparam logic [31:0] CMD_TOV_READ = 32'h0E00_0000;
    localparam logic [31:0] CMD_LINK_ERR = 32'h0F00_0000;
    localparam logic [31:0] CMD_ACCEPT = 32'h0200_0000;
    localparam logic [31:0] CMD_REJECT = 32'h0100_0000;
    // reason word for a reject: unable to perform command request
    localparam logic [31:0] RJT_UNABLE = 32'h0009_0000;

    // ****************************************************************
    // payload layout (word 1 and word 2 of a request)
    // ****************************************************************
    localparam int SEQ_ID_MSB = 31;
    localparam int SEQ_ID_LSB = 24;
    localparam int SID_MSB = 23;
    localparam int OXID_MSB = 31;
    localparam int OXID_LSB = 16;
    localparam int RXID_MSB = 15;

    // ****************************************************************
    // sizes of fixed reply blocks, in 32-bit words
    // ****************************************************************
    localparam int LESB_WORDS = 6;   // 24-byte link error status block
    localparam int ASSOC_WORDS = 8;  // 32-byte association header
    localparam int TOV_WORDS = 2;
    // timeout unit: one count is this many milliseconds
    localparam int TOV_UNIT_MS = 1;

    typedef enum logic [2:0] {
        SRL_K_NONE,
        SRL_K_XCHG,
        SRL_K_SEQ,
        SRL_K_TOV,
        SRL_K_LERR
    } srl_kind_t;

    // one word of a payload stream
    typedef struct packed {
        logic [31:0] data;
        logic last;
    } srl_word_t;

    // status lookup request to the local state store
    typedef struct packed {
        srl_kind_t kind;
        logic [7:0] seq_id;
        logic [23:0] orig_sid;
        logic [15:0] xid;      // rx_id as responder, ox_id as originator
    } srl_lookup_t;

endpackage : srl_pkg

// ### design/srl_responder.sv
/*
 * srl_responder: decodes read-type link service requests and streams
 * the accept or reject payload.
 * assumes: the state store answers a lookup with a hit flag and then
 * streams its status block words on demand; payload input is one word
 * per valid cycle; the reply sink may stall with reply_ready.
 */
// Summary of operation
// - exchange status request: 08000000, sid, ox_id, rx_id, opt header.
// - responder locates status by rx_id, originator by ox_id.
// - inconsistent seq_id, sid, ox_id or rx_id: reject, unable to perform; lookup carries seq_id, sid and rx_id (responder) or ox_id (originator).
// - exchange accept: 02000000, exchange block, optional assoc header.
// - link error request: 0F000000, reserved byte, port identifier.
// - fabric port without link error block rejects, unable to perform.
// - link error accept is 02000000 then a 24-byte status block.
// - sequence request is 09000000, seq_id, sid, ox_id, rx_id.
// - sequence accept is 02000000 then the sequence status block.
// - timeout request is command 0E000000 alone.
// - timeout accept: 02000000, allocation timeout, error detect timeout.
// - timeouts are counts of one millisecond.
// - every supported request gets exactly one accept or one reject.
`timescale 1ns/1ps

module srl_responder #(
    parameter int BLK_MAX = 16  // longest variable status block, words
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    // request payload stream
    input wire logic req_valid,
    input wire srl_pkg::srl_word_t req_word,
    output logic req_ready,
    // unrecognised command handed on
    output logic pass_valid,
    output srl_pkg::srl_word_t pass_word,
    input wire logic pass_ready,
    // local port configuration
    input wire logic is_responder,
    input wire logic is_fabric,
    input wire logic has_lesb,
    input wire logic assoc_needed,
    input wire logic [31:0] ra_tov_ms,
    input wire logic [31:0] ed_tov_ms,
    // status store lookup
    output logic look_valid,
    output srl_pkg::srl_lookup_t look_req,
    input wire logic look_done,
    input wire logic look_hit,
    input wire logic [7:0] look_len,
    input wire logic [31:0] blk_word,
    output logic blk_next,
    input wire logic [31:0] assoc_word,
    // reply payload stream
    output logic reply_valid,
    output srl_pkg::srl_word_t reply_word,
    input wire logic reply_ready
);

    typedef enum {
        ST_CMD, ST_W1, ST_W2, ST_DRAIN, ST_PASS, ST_LOOK,
        ST_HDR, ST_BODY, ST_ASSOC, ST_RJT
    } srl_state_t;

    // ****************************************************************
    // state
    // ****************************************************************
    srl_state_t state_r, state_nxt;
    srl_pkg::srl_kind_t kind_r;
    logic [31:0] w1_r, w2_r;
    logic [7:0] cnt_r, len_r;
    logic [31:0] out_r;
    logic out_last_r;

    // decode of the command word
    wire logic [31:0] cmd = req_word.data;
    wire logic is_xchg = (cmd == srl_pkg::CMD_XCHG_STAT);
    wire logic is_seq = (cmd == srl_pkg::CMD_SEQ_STAT);
    wire logic is_tov = (cmd == srl_pkg::CMD_TOV_READ);
    wire logic is_lerr = (cmd == srl_pkg::CMD_LINK_ERR);
    wire logic known = is_xchg | is_seq | is_tov | is_lerr;
    // kind of the request now arriving; the timeout read leaves the
    // command state straight for the reply, before kind_r is loaded
    wire srl_pkg::srl_kind_t kind_dec = is_xchg ? srl_pkg::SRL_K_XCHG :
        is_seq ? srl_pkg::SRL_K_SEQ :
        is_tov ? srl_pkg::SRL_K_TOV :
        is_lerr ? srl_pkg::SRL_K_LERR : srl_pkg::SRL_K_NONE;
    wire srl_pkg::srl_kind_t kind_now =
        (state_r == ST_CMD) ? kind_dec : kind_r;
    wire logic in_fire = req_valid & req_ready;
    wire logic out_fire = reply_valid & reply_ready;

    // status lookup key: which exchange id is used depends on our role
    assign look_req.kind = kind_r;
    assign look_req.seq_id = w1_r[srl_pkg::SEQ_ID_MSB:srl_pkg::SEQ_ID_LSB];
    assign look_req.orig_sid = w1_r[srl_pkg::SID_MSB:0];
    assign look_req.xid = is_responder ?
        w2_r[srl_pkg::RXID_MSB:0] :
        w2_r[srl_pkg::OXID_MSB:srl_pkg::OXID_LSB];
    assign look_valid = (state_r == ST_LOOK);

    // the store checks sid/ids consistency; a miss means inconsistent
    wire logic look_bad = look_done & ~look_hit;
    // fabric port without a link error block must refuse
    wire logic lerr_bad = is_fabric & ~has_lesb;
    wire logic lerr_rjt = (kind_r == srl_pkg::SRL_K_LERR) & lerr_bad;

    // handshakes: input taken while parsing or passing through
    // an unknown command word is itself forwarded, so it waits for
    // the pass sink just like the rest of that payload
    wire logic pass_now = (state_r == ST_PASS) |
        ((state_r == ST_CMD) & ~known);
    assign req_ready = ((state_r == ST_CMD) & known) | (state_r == ST_W1) |
        (state_r == ST_W2) | (state_r == ST_DRAIN) |
        (pass_now & pass_ready);
    assign pass_valid = pass_now & req_valid;
    assign pass_word = req_word;
    assign reply_valid = (state_r == ST_HDR) | (state_r == ST_BODY) |
        (state_r == ST_ASSOC) | (state_r == ST_RJT);
    assign reply_word.data = out_r;
    assign reply_word.last = out_last_r;

    // body length for each reply kind, in words after the accept word
    wire logic [7:0] body_len =
        (kind_now == srl_pkg::SRL_K_LERR) ? 8'(srl_pkg::LESB_WORDS) :
        (kind_now == srl_pkg::SRL_K_TOV) ? 8'(srl_pkg::TOV_WORDS) :
        (look_len > 8'(BLK_MAX)) ? 8'(BLK_MAX) : look_len;
    wire logic add_assoc = (kind_now == srl_pkg::SRL_K_XCHG) & assoc_needed;
    wire logic body_end = (cnt_r == len_r - 8'd1);

    // word loaded next into the reply register: the first one is taken
    // from the accept state, the rest from the body; timeouts pass
    // straight through since both sides count in whole milliseconds
    wire logic [31:0] body_word = (kind_r == srl_pkg::SRL_K_TOV) ?
        ((state_r == ST_HDR) ? ra_tov_ms : ed_tov_ms) :
        blk_word;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_CMD: begin
                if (in_fire) begin
                    if (!known) begin
                        state_nxt = req_word.last ? ST_CMD : ST_PASS;
                    end else if (is_tov) begin
                        state_nxt = req_word.last ? ST_HDR : ST_DRAIN;
                    end else if (req_word.last) begin
                        state_nxt = ST_RJT;  // too short to parse
                    end else begin
                        state_nxt = ST_W1;
                    end
                end
            end
            ST_W1: begin
                if (in_fire) begin
                    if (kind_r == srl_pkg::SRL_K_LERR && req_word.last) begin
                        // refuse before any accept word is shown
                        state_nxt = lerr_rjt ? ST_RJT : ST_HDR;
                    end else if (kind_r == srl_pkg::SRL_K_LERR) begin
                        state_nxt = ST_DRAIN;
                    end else if (req_word.last) begin
                        state_nxt = ST_RJT;
                    end else begin
                        state_nxt = ST_W2;
                    end
                end
            end
            ST_W2: begin
                if (in_fire) begin
                    state_nxt = req_word.last ? ST_LOOK : ST_DRAIN;
                end
            end
            // swallow trailing words such as the association header
            ST_DRAIN: begin
                if (in_fire && req_word.last) begin
                    if (kind_r == srl_pkg::SRL_K_XCHG ||
                        kind_r == srl_pkg::SRL_K_SEQ) begin
                        state_nxt = ST_LOOK;
                    end else begin
                        state_nxt = lerr_rjt ? ST_RJT : ST_HDR;
                    end
                end
            end
            ST_PASS: begin
                if (in_fire && req_word.last) begin
                    state_nxt = ST_CMD;
                end
            end
            ST_LOOK: begin
                if (look_bad) begin
                    state_nxt = ST_RJT;
                end else if (look_done) begin
                    state_nxt = ST_HDR;
                end
            end
            ST_HDR: begin
                if (out_fire) begin
                    state_nxt = (len_r == 8'd0) ?
                        (add_assoc ? ST_ASSOC : ST_CMD) : ST_BODY;
                end
            end
            ST_BODY: begin
                if (out_fire && body_end) begin
                    state_nxt = add_assoc ? ST_ASSOC : ST_CMD;
                end
            end
            ST_ASSOC: begin
                if (out_fire &&
                    cnt_r == 8'(srl_pkg::ASSOC_WORDS - 1)) begin
                    state_nxt = ST_CMD;
                end
            end
            ST_RJT: begin
                if (out_fire && out_last_r) begin
                    state_nxt = ST_CMD;
                end
            end
            default: state_nxt = ST_CMD;
        endcase
    end

    // ****************************************************************
    // reply word and counter; one reply per request, never two
    // ****************************************************************
    wire logic enter_hdr = (state_nxt == ST_HDR) & (state_r != ST_HDR);
    wire logic enter_rjt = (state_nxt == ST_RJT) & (state_r != ST_RJT);
    wire logic enter_asc = (state_nxt == ST_ASSOC) & (state_r != ST_ASSOC);
    wire logic enter_body = (state_nxt == ST_BODY) & (state_r == ST_HDR);
    // the store steps on as each block word is copied into the reply
    // register, so every word is read once and in order
    assign blk_next = (enter_body |
        ((state_r == ST_BODY) & out_fire & ~body_end)) &
        ((kind_r == srl_pkg::SRL_K_XCHG) | (kind_r == srl_pkg::SRL_K_SEQ) |
         (kind_r == srl_pkg::SRL_K_LERR));
    logic [31:0] out_nxt;
    logic out_last_nxt;

    always_comb begin
        out_nxt = out_r;
        out_last_nxt = out_last_r;
        if (enter_rjt) begin
            out_nxt = srl_pkg::CMD_REJECT;
            out_last_nxt = 1'b0;
        end else if (enter_hdr) begin
            out_nxt = srl_pkg::CMD_ACCEPT;
            out_last_nxt = (body_len == 8'd0) & ~add_assoc;
        end else if (state_r == ST_RJT && out_fire) begin
            out_nxt = srl_pkg::RJT_UNABLE;
            out_last_nxt = 1'b1;
        // the association header is entered on the last body fire, so it must win
        // over the body branch or a stray block word would be sent
        end else if (enter_asc || (state_r == ST_ASSOC && out_fire)) begin
            out_nxt = assoc_word;
            out_last_nxt = enter_asc ? 1'b0 :
                (cnt_r == 8'(srl_pkg::ASSOC_WORDS - 2));
        end else if (enter_body || (state_r == ST_BODY && out_fire)) begin
            out_nxt = body_word;
            out_last_nxt = (enter_body ? (len_r == 8'd1) :
                (cnt_r == len_r - 8'd2)) & ~add_assoc;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r <= ST_CMD;
            kind_r <= srl_pkg::SRL_K_NONE;
            w1_r <= 32'h0000_0000;
            w2_r <= 32'h0000_0000;
            out_r <= 32'h0000_0000;
            out_last_r <= 1'b0;
            len_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            out_r <= out_nxt;
            out_last_r <= out_last_nxt;
            if (state_r == ST_CMD && in_fire) begin
                kind_r <= kind_dec;
            end
            if (state_r == ST_W1 && in_fire) begin
                w1_r <= req_word.data;
            end
            if (state_r == ST_W2 && in_fire) begin
                w2_r <= req_word.data;
            end
            if (enter_hdr) begin
                len_r <= body_len;
            end
        end
    end

    // word counter restarts on the body and association sections of the reply
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cnt_r <= 8'h00;
        end else if (enter_body || enter_asc) begin
            cnt_r <= 8'h00;
        end else if (out_fire) begin
            cnt_r <= cnt_r + 8'd1;
        end
    end

endmodule : srl_responder

// ### sim/srl_responder_properties.sv
/* srl_chk_props: concurrent checks on the responder's ports.
 * assumes: one clock domain, bound to every srl_responder instance. */
`timescale 1ns/1ps
module srl_chk_props (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire srl_pkg::srl_word_t req_word,
    input wire logic req_ready,
    input wire logic pass_valid,
    input wire srl_pkg::srl_word_t pass_word,
    input wire logic is_responder,
    input wire logic is_fabric,
    input wire logic has_lesb,
    input wire logic look_valid,
    input wire srl_pkg::srl_lookup_t look_req,
    input wire logic look_done,
    input wire logic look_hit,
    input wire logic reply_valid,
    input wire srl_pkg::srl_word_t reply_word,
    input wire logic reply_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [1:0] idx_r;
    logic [31:0] w0_r, w1_r, w2_r;
    wire take = req_valid && req_ready;
    // word index of the request, kept to find command and id words
    always_ff @(posedge sys_clk) begin
        if (!reset_n) idx_r <= 2'h0;
        else if (take) idx_r <= req_word.last ? 2'h0 :
            (idx_r == 2'h3 ? idx_r : idx_r + 2'h1);
        if (take && idx_r == 2'h0) w0_r <= req_word.data;
        if (take && idx_r == 2'h1) w1_r <= req_word.data;
        if (take && idx_r == 2'h2) w2_r <= req_word.data;
    end
    sequence tov_cmd;
        take && idx_r == 2'h0 && req_word.last &&
            req_word.data == srl_pkg::CMD_TOV_READ;
    endsequence
    sequence acc_head;
        reply_valid && reply_word.data == srl_pkg::CMD_ACCEPT;
    endsequence
    sequence rjt_head;
        reply_valid && reply_word.data == srl_pkg::CMD_REJECT;
    endsequence
    tov_answer_a: assert property (tov_cmd |=> acc_head)
        else $error("timeout accept not one cycle after request");
    lesb_reject_a: assert property (take && req_word.last && idx_r == 2'h1
        && w0_r == srl_pkg::CMD_LINK_ERR && is_fabric && !has_lesb
        |=> rjt_head) else $error("link error read not rejected");
    rjt_reason_a: assert property (rjt_head ##0 reply_ready &&
        !reply_word.last |=> reply_valid && reply_word.last &&
        reply_word.data == srl_pkg::RJT_UNABLE)
        else $error("reject reason word wrong");
    reply_hold_a: assert property (reply_valid && !reply_ready
        |=> reply_valid && $stable(reply_word))
        else $error("reply word dropped during stall");
    reply_busy_a: assert property (reply_valid |-> !req_ready)
        else $error("request taken while replying");
    pass_through_a: assert property (pass_valid |->
        pass_word == req_word && !reply_valid)
        else $error("unknown command not passed cleanly");
    lookup_id_a: assert property (look_valid |-> look_req.xid ==
        (is_responder ? w2_r[15:0] : w2_r[31:16]))
        else $error("lookup uses wrong exchange id");
    lookup_key_a: assert property (look_valid |->
        look_req.seq_id == w1_r[31:24] && look_req.orig_sid == w1_r[23:0]
        && look_req.kind == (w0_r == srl_pkg::CMD_XCHG_STAT ?
        srl_pkg::SRL_K_XCHG : srl_pkg::SRL_K_SEQ))
        else $error("lookup key fields wrong");
    hit_accept_a: assert property (look_valid && look_done &&
        look_hit |=> acc_head) else $error("accept late after hit");
    miss_reject_a: assert property (look_valid && look_done &&
        !look_hit |=> rjt_head) else $error("reject late after miss");
endmodule : srl_chk_props
bind srl_responder srl_chk_props u_chk (.sys_clk, .reset_n, .req_valid,
    .req_word, .req_ready, .pass_valid, .pass_word, .is_responder,
    .is_fabric, .has_lesb, .look_valid, .look_req, .look_done,
    .look_hit, .reply_valid, .reply_word, .reply_ready);

// ### sim/srl_store.sv
/* srl_store: model of the local status store behind the responder.
 * assumes: driven by the bench for expected id, wait and block length. */
`timescale 1ns/1ps
module srl_store (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic look_valid,
    input wire srl_pkg::srl_lookup_t look_req,
    output logic look_done,
    output logic look_hit,
    output logic [7:0] look_len,
    output logic [31:0] blk_word,
    input wire logic blk_next,
    output logic [31:0] assoc_word,
    input wire logic [15:0] want_xid,
    input wire logic [1:0] delay,
    input wire logic [7:0] blk_len,
    input wire logic rewind
);
    logic [1:0] wait_r;
    logic [7:0] pos_r;
    // a programmable wait so slow stores are exercised, not only fast
    assign look_done = look_valid && (wait_r == delay);
    assign look_hit = look_req.xid == want_xid;
    assign look_len = blk_len;
    // word changes with position, so a stale or extra read shows up
    assign blk_word = {16'hB10C, 8'h00, pos_r};
    assign assoc_word = 32'hA55C_0000;
    // wait counter and block position
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !look_valid || look_done) wait_r <= 2'h0;
        else wait_r <= wait_r + 2'h1;
        if (!reset_n || look_valid || rewind) pos_r <= 8'h00;
        else if (blk_next) pos_r <= pos_r + 8'h01;
    end
endmodule : srl_store

// ### sim/tb_top.sv
/* tb_top: directed bench for the status read responder.
 * assumes: store model srl_store, checker bound from its own file. */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, reset_n, req_valid, req_ready, pass_valid, pass_ready;
    logic is_responder, is_fabric, has_lesb, assoc_needed, look_valid;
    logic look_done, look_hit, blk_next, reply_valid, reply_ready, rewind;
    logic [31:0] ra_tov_ms, ed_tov_ms, blk_word, assoc_word, pass_last;
    logic [7:0] look_len, blk_len;
    logic [15:0] want_xid;
    logic [1:0] delay;
    srl_pkg::srl_word_t req_word, pass_word, reply_word;
    srl_pkg::srl_lookup_t look_req;
    int failures = 0, checked = 0, cycles = 0, pass_n = 0;
    srl_responder uut (.sys_clk, .reset_n, .req_valid, .req_word,
        .req_ready, .pass_valid, .pass_word, .pass_ready, .is_responder,
        .is_fabric, .has_lesb, .assoc_needed, .ra_tov_ms, .ed_tov_ms,
        .look_valid, .look_req, .look_done, .look_hit, .look_len,
        .blk_word, .blk_next, .assoc_word, .reply_valid, .reply_word,
        .reply_ready);
    srl_store u_store (.sys_clk, .reset_n, .look_valid, .look_req,
        .look_done, .look_hit, .look_len, .blk_word, .blk_next,
        .assoc_word, .want_xid, .delay, .blk_len, .rewind);
    // ****************************************************************
    // clock, watchdog and pass monitor
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    always @(negedge sys_clk) begin
        if (pass_valid === 1'b1 && pass_ready === 1'b1) begin
            pass_n++;
            pass_last = pass_word.data;
        end
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic prep(input logic resp, fab, lesb, asc,
                        input logic [15:0] xid, input logic [1:0] dly,
                        input logic [7:0] len);
        @(posedge sys_clk);
        #1;
        {is_responder, is_fabric, has_lesb, assoc_needed} =
            {resp, fab, lesb, asc};
        {want_xid, delay, blk_len, rewind} = {xid, dly, len, 1'b1};
        @(posedge sys_clk);
        #1;
        rewind = 1'b0;
    endtask : prep
    // hold each word until it is taken, as the handshake demands
    task automatic send(input logic [31:0] d[$]);
        foreach (d[i]) begin
            req_valid = 1'b1;
            req_word = {d[i], i == d.size() - 1};
            do @(negedge sys_clk); while (req_ready !== 1'b1);
            @(posedge sys_clk);
            #1;
        end
        req_valid = 1'b0;
    endtask : send
    // ready low for hold cycles first, so a stalled reply is seen too
    task automatic collect(input logic [32:0] ex[$], input int hold);
        int k;
        int w;
        k = 0;
        w = 0;
        reply_ready = (hold == 0);
        while (k < ex.size() && w < 100) begin
            @(negedge sys_clk);
            w++;
            if (reply_valid === 1'b1 && reply_ready === 1'b1) begin
                check({reply_word.data, reply_word.last}, ex[k]);
                k++;
            end
            if (w == hold) begin
                @(posedge sys_clk);
                #1;
                reply_ready = 1'b1;
            end
        end
        if (k < ex.size()) check(33'h0, ex[k]);
    endtask : collect
    function automatic logic [32:0] blk(input int i, input logic last);
        return {16'hB10C, 8'h00, 8'(i), last};
    endfunction : blk
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_tov;
        prep(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 2'h0, 8'h00);
        send('{srl_pkg::CMD_TOV_READ});
        collect('{{srl_pkg::CMD_ACCEPT, 1'b0}, {ra_tov_ms, 1'b0},
            {ed_tov_ms, 1'b1}}, 2);
        $display("test tov done");
    endtask : t_tov
    task automatic t_lerr_node;
        logic [32:0] ex[$];
        prep(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 2'h0, 8'h00);
        send('{srl_pkg::CMD_LINK_ERR, 32'h00FF_FFFE});
        ex.push_back({srl_pkg::CMD_ACCEPT, 1'b0});
        for (int i = 0; i < 6; i++) ex.push_back(blk(i, i == 5));
        collect(ex, 0);
        $display("test link error accept done");
    endtask : t_lerr_node
    task automatic t_reject(input logic [31:0] d[$], input logic fab,
                            input logic [15:0] xid);
        prep(1'b1, fab, 1'b0, 1'b0, xid, 2'h1, 8'h02);
        send(d);
        collect('{{srl_pkg::CMD_REJECT, 1'b0},
            {srl_pkg::RJT_UNABLE, 1'b1}}, 1);
        $display("test reject done");
    endtask : t_reject
    task automatic t_status(input logic [31:0] cmd, input logic resp,
                            input logic asc, input logic [15:0] xid,
                            input logic [1:0] dly, input int n);
        logic [32:0] ex[$];
        logic [31:0] rq[$];
        prep(resp, 1'b0, 1'b1, asc, xid, dly, 8'(n));
        rq = '{cmd, 32'h0701_2345, 32'h0911_0042};
        // header follows when identifiers must be reassigned
        for (int i = 0; i < 8 && asc; i++)
            rq.push_back(32'hA550_0000 + 32'(i));
        send(rq);
        ex.push_back({srl_pkg::CMD_ACCEPT, 1'b0});
        for (int i = 0; i < n; i++) ex.push_back(blk(i, !asc && i == n - 1));
        for (int i = 0; i < 8 && asc; i++)
            ex.push_back({assoc_word, i == 7});
        collect(ex, 0);
        $display("test status accept done");
    endtask : t_status
    task automatic t_unknown;
        pass_n = 0;
        prep(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 2'h0, 8'h00);
        send('{32'h0500_0000, 32'h0012_3456});
        repeat (4) @(negedge sys_clk);
        check(33'(pass_n), 33'h0_0000_0002);
        check({1'b0, pass_last}, {1'b0, 32'h0012_3456});
        check({32'h0, reply_valid}, 33'h0);
        $display("test unknown command done");
    endtask : t_unknown
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {reset_n, req_valid, pass_ready, reply_ready, rewind} = 5'b00110;
        req_word = '0;
        {is_responder, is_fabric, has_lesb, assoc_needed} = 4'b1010;
        {want_xid, delay, blk_len} = '0;
        ra_tov_ms = 32'h0000_000A;
        ed_tov_ms = 32'h0000_07D0;
        repeat (12) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_tov();
        t_tov();
        t_lerr_node();
        t_reject('{srl_pkg::CMD_LINK_ERR, 32'h00FF_FFFE}, 1'b1, 16'h0);
        t_status(srl_pkg::CMD_XCHG_STAT, 1'b1, 1'b1, 16'h0042, 2'h2, 3);
        t_status(srl_pkg::CMD_SEQ_STAT, 1'b0, 1'b0, 16'h0911, 2'h0, 2);
        t_reject('{srl_pkg::CMD_SEQ_STAT, 32'h0701_2345, 32'h0911_0042},
            1'b0, 16'h0911);
        t_unknown();
        tally_and_finish();
    end
endmodule : tb_top
